// [rtl/psf_pkg.sv]
// Purpose: Constants for the processor status flag block
// Assumes: 16-bit status word, flag positions fixed
// Notes:   Shared by the flag register and its users
package psf_pkg;

  // ----------------------------------------
  // Status word layout
  // ----------------------------------------
  localparam int unsigned WORD_W       = 16;
  localparam int unsigned BIT_CARRY    = 0;
  localparam int unsigned BIT_PARITY   = 2;
  localparam int unsigned BIT_AUX      = 4;
  localparam int unsigned BIT_ZERO     = 6;
  localparam int unsigned BIT_SIGN     = 7;
  localparam int unsigned BIT_TRAP     = 8;
  localparam int unsigned BIT_IEN      = 9;
  localparam int unsigned BIT_DIR      = 10;
  localparam int unsigned BIT_OVF      = 11;
  localparam int unsigned LOW_BYTE_W   = 8;

  // Writable bits of the word; the rest read as zero
  localparam logic [15:0] FLAGS_MASK   = 16'h0FD5;
  // Bits carried by the high accumulator byte transfer
  localparam logic [7:0]  ACC_MASK     = 8'hD5;
  localparam logic [15:0] FLAGS_RESET  = 16'h0000;

  // ----------------------------------------
  // Update selects per result flag, one bit each
  // ----------------------------------------
  localparam int unsigned UPD_W        = 6;
  localparam int unsigned UPD_CARRY    = 0;
  localparam int unsigned UPD_PARITY   = 1;
  localparam int unsigned UPD_AUX      = 2;
  localparam int unsigned UPD_ZERO     = 3;
  localparam int unsigned UPD_SIGN     = 4;
  localparam int unsigned UPD_OVF      = 5;

  // ----------------------------------------
  // Byte and word transfer commands, plus control bit writes
  // ----------------------------------------
  typedef enum logic [2:0] {
    PSF_CMD_NONE     = 3'h0,
    PSF_CMD_TO_ACC   = 3'h1,
    PSF_CMD_FROM_ACC = 3'h2,
    PSF_CMD_PUSH     = 3'h3,
    PSF_CMD_POP      = 3'h4,
    PSF_CMD_CTRL     = 3'h5
  } psf_cmd_t;

endpackage : psf_pkg

// [rtl/psf_flags.sv]
// Purpose: Processor status word with result and control flags
// Assumes: Datapath and sequencer share sys_clk_i; inputs are synchronous
// Notes:   Flag results are registered; outputs come straight from flops
//
// Behaviour
// (RQ1) Status word is one 16-bit register
// (RQ2) Bit 0 set on high-order carry/borrow
// (RQ3) Bit 2 set for even ones in low byte
// (RQ4) Bit 4 set on carry/borrow at nibble
// (RQ5) Bit 6 set when result is zero
// (RQ6) Bit 7 copies result top bit
// (RQ7) Bit 8 traps after next instruction
// (RQ8) Taking single-step trap clears bit 8
// (RQ9) Bit 9 gates maskable interrupt requests
// (RQ10) Bit 10 selects index decrement or increment
// (RQ11) Bit 11 set on signed overflow
// (RQ12) Flags move to/from high accumulator byte
// (RQ13) Whole word pushed to and popped from stack
// (RQ14) Only defined flags change per operation
`timescale 1ns/100ps
module psf_flags
  import psf_pkg::*;
(
  input  wire logic        sys_clk_i,
  input  wire logic        rstn_i,
  // Arithmetic/logic result
  input  wire logic        alu_valid_i,
  input  wire logic        alu_word_i,
  input  wire logic [15:0] alu_result_i,
  input  wire logic        alu_carry_i,
  input  wire logic        alu_aux_i,
  input  wire logic        alu_ovf_i,
  input  wire logic [5:0]  alu_upd_i,
  // Byte/word transfers and control bit writes
  input  wire psf_cmd_t    cmd_i,
  input  wire logic [7:0]  high_accumulator_byte_i,
  input  wire logic [15:0] stack_word_i,
  input  wire logic [15:0] ctrl_set_i,
  input  wire logic [15:0] ctrl_clr_i,
  // Sequencing
  input  wire logic        insn_done_i,
  input  wire logic        trap_taken_i,
  input  wire logic        irq_req_i,
  // Outputs
  output logic [15:0]      processor_flags_word_o,
  output logic [7:0]       high_accumulator_byte_o,
  output logic             trap_req_o,
  output logic             irq_accept_o,
  output logic             index_dec_o
);

  // ----------------------------------------
  // Flag evaluation
  // ----------------------------------------
  logic [15:0] processor_flags_word_q;
  logic [15:0] processor_flags_word_d;
  logic [7:0]  high_acc_q;
  logic        trap_armed_q;
  logic        trap_req_q;
  logic        irq_accept_q;

  function automatic logic even_parity(input logic [7:0] v);
    even_parity = ~^v;
  endfunction : even_parity

  function automatic logic [15:0] pick(input logic [15:0] cur, input int unsigned pos,
                                       input logic en, input logic val);
    logic [15:0] r;
    r = cur;
    if (en) begin
      r[pos] = val;
    end
    pick = r;
  endfunction : pick

  always_comb begin
    processor_flags_word_d = processor_flags_word_q;
    if (alu_valid_i) begin
      // Untouched bits hold their value
      processor_flags_word_d = pick(processor_flags_word_d, BIT_CARRY, alu_upd_i[UPD_CARRY],
                                    alu_carry_i); // RQ2 RQ14
      processor_flags_word_d = pick(processor_flags_word_d, BIT_PARITY, alu_upd_i[UPD_PARITY],
                                    even_parity(alu_result_i[LOW_BYTE_W-1:0])); // RQ3
      processor_flags_word_d = pick(processor_flags_word_d, BIT_AUX, alu_upd_i[UPD_AUX],
                                    alu_aux_i); // RQ4
      processor_flags_word_d = pick(processor_flags_word_d, BIT_ZERO, alu_upd_i[UPD_ZERO],
                                    alu_result_i == 16'h0000); // RQ5
      // Byte results arrive sign-extended, so the top bit is the sign
      processor_flags_word_d = pick(processor_flags_word_d, BIT_SIGN, alu_upd_i[UPD_SIGN],
                                    alu_result_i[WORD_W-1]); // RQ6
      processor_flags_word_d = pick(processor_flags_word_d, BIT_OVF, alu_upd_i[UPD_OVF],
                                    alu_ovf_i); // RQ11
    end
    unique case (cmd_i)
      PSF_CMD_FROM_ACC: processor_flags_word_d[7:0] =
          (processor_flags_word_d[7:0] & ~ACC_MASK) | (high_accumulator_byte_i & ACC_MASK); // RQ12
      PSF_CMD_POP:      processor_flags_word_d = stack_word_i & FLAGS_MASK; // RQ13
      PSF_CMD_CTRL:     processor_flags_word_d = ((processor_flags_word_d & ~ctrl_clr_i) | ctrl_set_i)
                                                 & FLAGS_MASK;
      default:          processor_flags_word_d = processor_flags_word_d;
    endcase
    // Trap entry wins over any write in the same cycle
    if (trap_taken_i) begin
      processor_flags_word_d[BIT_TRAP] = 1'b0; // RQ8
    end
  end

  // ----------------------------------------
  // Status word register
  // ----------------------------------------
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      processor_flags_word_q <= FLAGS_RESET;
    end else begin
      processor_flags_word_q <= processor_flags_word_d; // RQ1
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      high_acc_q <= 8'h00;
    end else if (cmd_i == PSF_CMD_TO_ACC) begin
      high_acc_q <= processor_flags_word_q[7:0] & ACC_MASK; // RQ12
    end
  end

  // ----------------------------------------
  // Single-step trap
  // ----------------------------------------
  // Armed when an instruction starts with the bit set, so the instruction
  // that sets it is not itself trapped.
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      trap_armed_q <= 1'b0;
      trap_req_q   <= 1'b0;
    end else begin
      if (trap_taken_i) begin
        trap_req_q <= 1'b0; // RQ8
      end else if (insn_done_i && trap_armed_q) begin
        trap_req_q <= 1'b1; // RQ7
      end
      if (trap_taken_i) begin
        trap_armed_q <= 1'b0;
      end else if (insn_done_i) begin
        trap_armed_q <= processor_flags_word_q[BIT_TRAP]; // RQ7
      end
    end
  end

  // ----------------------------------------
  // Interrupt gate
  // ----------------------------------------
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_accept_q <= 1'b0;
    end else begin
      irq_accept_q <= irq_req_i && processor_flags_word_q[BIT_IEN]; // RQ9
    end
  end

  assign processor_flags_word_o  = processor_flags_word_q; // RQ13
  assign high_accumulator_byte_o = high_acc_q;
  assign trap_req_o              = trap_req_q;
  assign irq_accept_o            = irq_accept_q;
  assign index_dec_o             = processor_flags_word_q[BIT_DIR]; // RQ10

endmodule : psf_flags

// [verif/psf_monitor.sv]
// Purpose: Port assertions for the status flag block
// Assumes: One clock, async active-low reset
// Notes:   Result checks only on cycles with no command
`timescale 1ns/100ps
module psf_monitor
  import psf_pkg::*;
(
  input wire logic        sys_clk_i,
  input wire logic        rstn_i,
  input wire logic        alu_valid_i,
  input wire logic [15:0] alu_result_i,
  input wire logic        alu_carry_i,
  input wire logic        alu_aux_i,
  input wire logic        alu_ovf_i,
  input wire logic [5:0]  alu_upd_i,
  input wire psf_cmd_t    cmd_i,
  input wire logic        trap_taken_i,
  input wire logic        irq_req_i,
  input wire logic [15:0] processor_flags_word_o,
  input wire logic [7:0]  high_accumulator_byte_o,
  input wire logic        trap_req_o,
  input wire logic        irq_accept_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  wire [15:0] w  = processor_flags_word_o;
  wire        ao = alu_valid_i && cmd_i == PSF_CMD_NONE;
  chk_carry_upd: assert property (ao && alu_upd_i[0] |=> w[0] == $past(alu_carry_i)) else $error("carry bad");
  chk_parity_upd: assert property (ao && alu_upd_i[1] |=> w[2] == ~^($past(alu_result_i) & 16'h00FF))
    else $error("parity bad");
  chk_aux_upd: assert property (ao && alu_upd_i[2] |=> w[4] == $past(alu_aux_i)) else $error("aux bad");
  chk_zero_upd: assert property (ao && alu_upd_i[3] |=> w[6] == ($past(alu_result_i) == 16'h0000))
    else $error("zero bad");
  chk_sign_upd: assert property (ao && alu_upd_i[4] |=> w[7] == $past(alu_result_i[15])) else $error("sign bad");
  chk_ovf_upd: assert property (ao && alu_upd_i[5] |=> w[11] == $past(alu_ovf_i)) else $error("ovf bad");
  chk_word_rsvd: assert property ((w & ~FLAGS_MASK) == 16'h0000) else $error("reserved bit set");
  chk_idle_hold: assert property (!alu_valid_i && cmd_i == PSF_CMD_NONE && !trap_taken_i |=> $stable(w))
    else $error("word moved");
  chk_trap_clear: assert property (trap_taken_i |=> !w[8] && !trap_req_o) else $error("trap not cleared");
  chk_irq_gate: assert property (irq_accept_o == ($past(irq_req_i) && $past(w[9]))) else $error("irq gate");
  chk_acc_copy: assert property (cmd_i == PSF_CMD_TO_ACC && !alu_valid_i |=> high_accumulator_byte_o == $past(w[7:0]))
    else $error("acc copy");
endmodule : psf_monitor
bind psf_flags psf_monitor psf_monitor_inst (.*);

// [verif/psf_seq_model.sv]
// Purpose: Instruction sequencer model for the flag block
// Assumes: Step requests come from the bench
// Notes:   Slow mode delays trap entry to stress a pending trap
`timescale 1ns/100ps
module psf_seq_model (
  input  wire logic sys_clk_i,
  input  wire logic rstn_i,
  input  wire logic trap_req_i,
  input  wire logic step_i,
  input  wire logic slow_i,
  output logic      insn_done_o,
  output logic      trap_taken_o
);
  logic [1:0] wait_q;
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      insn_done_o  <= 1'b0;
      trap_taken_o <= 1'b0;
      wait_q       <= 2'h0;
    end else begin
      insn_done_o  <= step_i;
      trap_taken_o <= 1'b0;
      if (trap_req_i && !trap_taken_o) begin
        wait_q <= wait_q + 2'h1;
        if (!slow_i || wait_q == 2'h2) begin
          trap_taken_o <= 1'b1;
          wait_q       <= 2'h0;
        end
      end
    end
  end
endmodule : psf_seq_model

// [verif/psf_flags_bench.sv]
// Purpose: Self-checking bench for the status flag block
// Assumes: Inputs change on the falling edge
// Notes:   Watchdog span far above the fewer than 60 cycles used
`timescale 1ns/100ps
module psf_flags_bench
  import psf_pkg::*;
;
  logic sys_clk_i = 0, rstn_i = 0, alu_valid_i = 0, alu_word_i = 1, alu_carry_i = 0, alu_aux_i = 0, alu_ovf_i = 0;
  logic [15:0] alu_result_i = 0, stack_word_i = 0, ctrl_set_i = 0, ctrl_clr_i = 0, processor_flags_word_o;
  logic [7:0] high_accumulator_byte_i = 0, high_accumulator_byte_o;
  logic [5:0] alu_upd_i = 0;
  psf_cmd_t cmd_i = PSF_CMD_NONE;
  logic insn_done_i, trap_taken_i, irq_req_i = 0, trap_req_o, irq_accept_o, index_dec_o, step = 0;
  int error_cnt = 0, tests_run = 0;
  psf_flags psf_flags_inst (.*);
  psf_seq_model psf_seq_model_inst (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .trap_req_i(trap_req_o), .step_i(step),
    .slow_i(1'b1), .insn_done_o(insn_done_i), .trap_taken_o(trap_taken_i));
  always #2 sys_clk_i = ~sys_clk_i;
  task automatic chk(string n, logic [15:0] s, logic [15:0] e);
    tests_run++;
    if (s !== e) begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task automatic tick();
    @(negedge sys_clk_i);
    {alu_valid_i, step} = 2'h0;
    cmd_i = PSF_CMD_NONE;
    @(negedge sys_clk_i);
  endtask : tick
  task automatic finish_test();
    $display("tests %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test
  initial begin
    #20000;
    error_cnt++;
    finish_test();
  end
  initial begin
    repeat (20) @(negedge sys_clk_i);
    rstn_i = 1;
    chk("reset", processor_flags_word_o, FLAGS_RESET);
    {alu_valid_i, alu_upd_i, alu_result_i} = {1'b1, 6'h3F, 16'h0000};
    tick();
    chk("zero", processor_flags_word_o, 16'h0044);
    {alu_valid_i, alu_result_i, alu_carry_i, alu_aux_i, alu_ovf_i} = {1'b1, 16'h8001, 3'h7};
    tick();
    chk("alu", processor_flags_word_o, 16'h0891);
    {alu_valid_i, alu_upd_i, alu_carry_i} = {1'b1, 6'h01, 1'b0};
    tick();
    chk("partial", processor_flags_word_o, 16'h0890);
    $display("test alu done");
    {cmd_i, high_accumulator_byte_i} = {PSF_CMD_FROM_ACC, 8'hFF};
    tick();
    chk("from acc", processor_flags_word_o, 16'h08D5);
    cmd_i = PSF_CMD_TO_ACC;
    tick();
    chk("to acc", high_accumulator_byte_o, 16'h00D5);
    {cmd_i, stack_word_i, irq_req_i} = {PSF_CMD_POP, 16'hFFFF, 1'b1};
    tick();
    chk("pop", processor_flags_word_o, 16'h0FD5);
    chk("dir", index_dec_o, 16'h0001);
    chk("irq on", irq_accept_o, 16'h0001);
    cmd_i = PSF_CMD_PUSH;
    tick();
    chk("push", processor_flags_word_o, 16'h0FD5);
    {cmd_i, ctrl_clr_i} = {PSF_CMD_CTRL, 16'h0FFF};
    tick();
    chk("irq off", irq_accept_o, 16'h0000);
    $display("test word done");
    {cmd_i, ctrl_set_i} = {PSF_CMD_CTRL, 16'h0100};
    tick();
    step = 1;
    tick();
    chk("trap early", trap_req_o, 16'h0000);
    step = 1;
    tick();
    repeat (10) if (!trap_req_o) @(negedge sys_clk_i);
    chk("trap req", trap_req_o, 16'h0001);
    repeat (6) @(negedge sys_clk_i);
    chk("trap clr", processor_flags_word_o, 16'h0000);
    $display("test trap done");
    finish_test();
  end
endmodule : psf_flags_bench
